// ==== hdl/lbms_pkg.sv ====
// Shared constants and types of the local bus memory subsystem
package lbms_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_SWAIT = 8'h04;
  localparam logic [7:0] REG_DBASE = 8'h08;
  localparam logic [7:0] REG_DMASK = 8'h0c;
  localparam logic [7:0] REG_STAT  = 8'h10;
  localparam logic [7:0] REG_TIME  = 8'h14;
  localparam logic [7:0] REG_DATE  = 8'h18;
  // Control bit positions
  localparam int CTL_DEN  = 0;
  localparam int CTL_PEN  = 1;
  localparam int CTL_PEXC = 2;
  localparam int CTL_D4M  = 3;
  // Reset values
  localparam logic [3:0]  CTRL_RST  = 4'h0;
  localparam logic [3:0]  SWAIT_RST = 4'h3;
  localparam logic [11:0] DBASE_RST = 12'h000;
  localparam logic [11:0] DMASK_RST = 12'hfff;
  localparam logic [7:0]  TOD_ONE   = 8'h01;
  // Fixed region tags (upper address bits)
  localparam logic [9:0]  BOOT_TAG = 10'h3fe;
  localparam logic [14:0] SONB_TAG = 15'h7ff0;
  localparam logic [10:0] SMEZ_TAG = 11'h7ff;
  localparam logic [18:0] TOD_TAG  = 19'h7ffe0;
  localparam int          ROM_AW0  = 17;
  // AXI responses
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef enum logic [2:0] {R_NONE, R_TOD, R_SRAM, R_BOOT, R_DRAM}
    lbms_region_t;
  typedef enum logic [2:0] {ST_IDLE, ST_SRAM, ST_EXT, ST_TREQ, ST_TCAP}
    lbms_acc_t;
endpackage

// ==== hdl/lbms_mem_if.sv ====
// Byte port between the clock-chip sequencer and its battery RAM
interface lbms_mem_if #(parameter int AW = 13);
  logic          en;
  logic          we;
  logic [AW-1:0] addr;
  logic [7:0]    wdata;
  logic [7:0]    rdata;
  modport ctl (output en, output we, output addr, output wdata,
               input rdata);
  modport mem (input en, input we, input addr, input wdata,
               output rdata);
endinterface

// ==== hdl/lbms_bbram.sv ====
// Byte-wide battery-backed RAM with registered read data
module lbms_bbram #(
  parameter int AW = 13
) (
  // Clock
  input wire logic clk_sys,
  input wire logic ce,
  // Byte port
  lbms_mem_if.mem  m
);
  logic [7:0] ram [2**AW];

  always_ff @(posedge clk_sys)
  begin
    if (ce && m.en)
    begin
      if (m.we)
        ram[m.addr] <= m.wdata;
      m.rdata <= ram[m.addr];
    end
  end
endmodule

// ==== hdl/lbms_top.sv ====
// Local bus memory subsystem: arbiter, decode, SRAM, DRAM, clock chip
// Operation
// [RL1] 32-bit synchronous local bus, bursts, snooping; here single accesses only, no bursts or snooping
// [RL2] Fixed priority: network, mezzanine, disk, bridge, processor
// [RL3] Boot strap picks flash or socketed ROMs
// [RL4] Four strap-selected ROM densities, 128K to 1M
// [RL5] Flash is one byte-wide 1M x 8 device
// [RL6] Onboard SRAM 128 KB, 32-bit, non-interleaved
// [RL7] Mezzanine SRAM present disables onboard SRAM
// [RL8] SRAM has no parity
// [RL9] Low backup supply blocks second SRAM cycle
// [RL10] Software does two SRAM accesses before trusting
// [RL11] SRAM access time programmable in cycles
// [RL12] DRAM 1MB single bank, 4MB interleaved
// [RL13] DRAM parity error: interrupt or bus exception
// [RL14] DRAM decoder: programmable base and size
// [RL15] Reset disables DRAM until software programs decoder
// [RL16] Software runs ten init cycles per bank
// [RL17] Clock keeps BCD time, 24-hour hours
// [RL18] Calendar handles 28, 29, 30 day months
// [RL19] Clock never raises an interrupt
// [RL20] Clock interface accepts 8, 16, 32-bit accesses
// [RL21] 8 KB battery RAM, write-protected on power fail
// [RL22] Wide clock accesses split into ascending bytes
// [RL23] One owner; re-arbitrate after transfer completes
module lbms_top #(
  parameter int NMST   = 5,
  parameter int TOD_AW = 13
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             ce,
  // AXI4-Lite register slave
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  output logic [1:0]            s_axi_bresp,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  input  wire logic [7:0]       s_axi_araddr,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  // Local bus arbitration
  input  wire logic [NMST-1:0]  lb_req,
  input  wire logic             lb_busy,
  output logic [NMST-1:0]       lb_gnt,
  // Straps and supply status
  input  wire logic             boot_source_strap,
  input  wire logic [1:0]       rom_density_strap,
  input  wire logic             sram_mezz_present,
  input  wire logic             backup_low,
  input  wire logic             power_fail,
  input  wire logic             tod_tick,
  // Local bus slave access
  input  wire logic             acc_valid,
  input  wire logic [31:0]      acc_addr,
  input  wire logic [1:0]       acc_size,
  input  wire logic             acc_we,
  input  wire logic [31:0]      acc_wdata,
  output logic                  acc_ready,
  output logic [31:0]           acc_rdata,
  output logic                  acc_err,
  // Memory device side
  output logic [31:0]           mem_addr,
  output logic                  mem_we,
  output logic [31:0]           mem_wdata,
  output logic                  flash_cs,
  output logic                  rom_cs,
  output logic [1:0]            rom_sock,
  output logic                  sram_onb_cs,
  output logic                  sram_mez_cs,
  output logic                  dram_cs,
  output logic                  dram_bank,
  input  wire logic             ext_ack,
  input  wire logic [31:0]      ext_rdata,
  input  wire logic [3:0]       ext_rpar,
  output logic                  boot_flash_sel,
  output logic                  par_irq
);
  if (NMST < 1 || NMST > 5 || TOD_AW < 2 || TOD_AW > 19)
    $error("lbms_top: unsupported parameter values");

  lbms_mem_if #(.AW(TOD_AW)) tm ();
  lbms_bbram #(.AW(TOD_AW)) u_ram (.clk_sys(clk_sys), .ce(ce), .m(tm));

  logic [3:0]  ctrl_reg;
  logic [3:0]  swait_reg;
  logic [11:0] dbase_reg;
  logic [11:0] dmask_reg;
  logic [7:0]  sec_reg, min_reg, hour_reg, day_reg;
  logic [7:0]  date_reg, mon_reg, year_reg;
  logic        aw_full, w_full;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        do_wr;
  lbms_pkg::lbms_acc_t st;
  logic [3:0]  wcnt;
  logic [1:0]  idx, last;
  logic [1:0]  sram_seq;
  logic [3:0]  lane_bad;
  logic        par_bad, sram_start, blk;

  function automatic logic [31:0] wmerge(input logic [31:0] o,
    input logic [31:0] n, input logic [3:0] s);
    for (int i = 0; i < 4; i++)
      if (s[i])
        o[8*i +: 8] = n[8*i +: 8];
    return o;
  endfunction

  function automatic logic known(input logic [7:0] a);
    return a inside {lbms_pkg::REG_CTRL, lbms_pkg::REG_SWAIT,
      lbms_pkg::REG_DBASE, lbms_pkg::REG_DMASK, lbms_pkg::REG_STAT,
      lbms_pkg::REG_TIME, lbms_pkg::REG_DATE};
  endfunction

  function automatic lbms_pkg::lbms_region_t region(
    input logic [31:0] a, input logic mez);
    if (a[31:13] == lbms_pkg::TOD_TAG)
      return lbms_pkg::R_TOD;
    else if (mez ? a[31:21] == lbms_pkg::SMEZ_TAG
                 : a[31:17] == lbms_pkg::SONB_TAG)  // [RL6] [RL7]
      return lbms_pkg::R_SRAM;
    else if (a[31:22] == lbms_pkg::BOOT_TAG)
      return lbms_pkg::R_BOOT;
    else if (ctrl_reg[lbms_pkg::CTL_DEN] &&
             ((a[31:20] ^ dbase_reg) & dmask_reg) == 12'h000)  // [RL14]
      return lbms_pkg::R_DRAM;
    return lbms_pkg::R_NONE;
  endfunction

  function automatic logic [NMST-1:0] pick(input logic [NMST-1:0] r);
    logic [NMST-1:0] g;
    g = '0;
    for (int i = NMST - 1; i >= 0; i--)
      if (r[i])
        g = '0 | (NMST'(1) << i);
    return g;
  endfunction

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction

  function automatic logic [7:0] dim(input logic [7:0] m,
    input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    case (m)
      8'h02: return leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default: return 8'h31;
    endcase
  endfunction

  // Arbiter: index 0 is the network controller, the top the processor
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      lb_gnt <= '0;
    else if (ce && !lb_busy && (lb_gnt & lb_req) == '0)  // [RL23]
      lb_gnt <= pick(lb_req);  // [RL1] [RL2]
  end

  // Strap captured while reset is held, so no async path from the pin
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      boot_flash_sel <= boot_source_strap;  // [RL3]
  end

  // AXI write channel: address and data may arrive in either order
  assign s_axi_awready = ce && !aw_full;
  assign s_axi_wready  = ce && !w_full;
  assign s_axi_arready = ce && !s_axi_rvalid;
  assign do_wr = ce && aw_full && w_full && !s_axi_bvalid;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      aw_full      <= 1'b0;
      w_full       <= 1'b0;
      awaddr_reg   <= 8'h00;
      wdata_reg    <= 32'h0000_0000;
      wstrb_reg    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= lbms_pkg::RESP_OK;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full    <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full    <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_wr)
      begin
        aw_full      <= 1'b0;
        w_full       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= known(awaddr_reg) ? lbms_pkg::RESP_OK
                                          : lbms_pkg::RESP_ERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Configuration registers; DRAM decoder starts disabled
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ctrl_reg  <= lbms_pkg::CTRL_RST;  // [RL15]
      swait_reg <= lbms_pkg::SWAIT_RST;
      dbase_reg <= lbms_pkg::DBASE_RST;
      dmask_reg <= lbms_pkg::DMASK_RST;
    end
    else if (do_wr)
    begin
      if (awaddr_reg == lbms_pkg::REG_CTRL && wstrb_reg[0])
        ctrl_reg <= wdata_reg[3:0];
      if (awaddr_reg == lbms_pkg::REG_SWAIT && wstrb_reg[0])
        swait_reg <= wdata_reg[3:0];  // [RL11]
      if (awaddr_reg == lbms_pkg::REG_DBASE)
        dbase_reg <= 12'(wmerge({20'h0, dbase_reg}, wdata_reg,
                     wstrb_reg));  // [RL14]
      if (awaddr_reg == lbms_pkg::REG_DMASK)
        dmask_reg <= 12'(wmerge({20'h0, dmask_reg}, wdata_reg,
                     wstrb_reg));
    end
  end

  // Time of day; a software write wins over the seconds tick.
  // No alarm or interrupt output exists here. [RL19]
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      {sec_reg, min_reg, hour_reg} <= 24'h000000;
      day_reg  <= lbms_pkg::TOD_ONE;
      date_reg <= lbms_pkg::TOD_ONE;
      mon_reg  <= lbms_pkg::TOD_ONE;
      year_reg <= 8'h00;
    end
    else if (do_wr && awaddr_reg == lbms_pkg::REG_TIME)
      {hour_reg, min_reg, sec_reg} <= 24'(wmerge({8'h00, hour_reg,
        min_reg, sec_reg}, wdata_reg, wstrb_reg));
    else if (do_wr && awaddr_reg == lbms_pkg::REG_DATE)
      {year_reg, mon_reg, date_reg, day_reg} <= wmerge({year_reg,
        mon_reg, date_reg, day_reg}, wdata_reg, wstrb_reg);
    else if (ce && tod_tick)
    begin
      sec_reg <= (sec_reg == 8'h59) ? 8'h00 : bcd_inc(sec_reg);  // [RL17]
      if (sec_reg == 8'h59)
      begin
        min_reg <= (min_reg == 8'h59) ? 8'h00 : bcd_inc(min_reg);
        if (min_reg == 8'h59)
        begin
          hour_reg <= (hour_reg == 8'h23) ? 8'h00 : bcd_inc(hour_reg);
          if (hour_reg == 8'h23)
          begin
            day_reg <= (day_reg == 8'h07) ? lbms_pkg::TOD_ONE
                                          : bcd_inc(day_reg);
            if (date_reg == dim(mon_reg, year_reg))  // [RL18]
            begin
              date_reg <= lbms_pkg::TOD_ONE;
              mon_reg  <= (mon_reg == 8'h12) ? lbms_pkg::TOD_ONE
                                             : bcd_inc(mon_reg);
              if (mon_reg == 8'h12)
                year_reg <= (year_reg == 8'h99) ? 8'h00
                                                : bcd_inc(year_reg);
            end
            else
              date_reg <= bcd_inc(date_reg);
          end
        end
      end
    end
  end

  // AXI read channel
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= lbms_pkg::RESP_OK;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= known(s_axi_araddr) ? lbms_pkg::RESP_OK
                                            : lbms_pkg::RESP_ERR;
        case (s_axi_araddr)
          lbms_pkg::REG_CTRL:  s_axi_rdata <= {28'h0, ctrl_reg};
          lbms_pkg::REG_SWAIT: s_axi_rdata <= {28'h0, swait_reg};
          lbms_pkg::REG_DBASE: s_axi_rdata <= {20'h0, dbase_reg};
          lbms_pkg::REG_DMASK: s_axi_rdata <= {20'h0, dmask_reg};
          lbms_pkg::REG_STAT:  s_axi_rdata <= {20'h0,
            lb_gnt[NMST-1:0] | 5'h00, 1'b0, power_fail, backup_low,
            sram_mezz_present, rom_density_strap, boot_flash_sel};
          lbms_pkg::REG_TIME:  s_axi_rdata <= {8'h00, hour_reg,
            min_reg, sec_reg};
          lbms_pkg::REG_DATE:  s_axi_rdata <= {year_reg, mon_reg,
            date_reg, day_reg};
          default:             s_axi_rdata <= 32'h0000_0000;
        endcase
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Odd parity per DRAM byte lane
  for (genvar i = 0; i < 4; i++)
  begin : g_par
    assign lane_bad[i] = ~^{ext_rdata[8*i +: 8], ext_rpar[i]};
  end
  assign par_bad = |lane_bad;

  // Backup supply watch: the second SRAM cycle after it drops is lost
  assign sram_start = ce && st == lbms_pkg::ST_IDLE && acc_valid &&
    !acc_ready && region(acc_addr, sram_mezz_present) ==
    lbms_pkg::R_SRAM;
  assign blk = backup_low && sram_seq == 2'd1;

  always_ff @(posedge clk_sys)
  begin
    if (rst || (ce && !backup_low))
      sram_seq <= 2'd0;
    else if (sram_start && sram_seq != 2'd2)
      sram_seq <= sram_seq + 2'd1;
  end

  // Clock-chip byte port; power fail write-protects the RAM
  assign tm.en    = ce && st == lbms_pkg::ST_TREQ;
  assign tm.we    = mem_we && !power_fail;  // [RL21]
  assign tm.addr  = mem_addr[TOD_AW-1:0] + TOD_AW'(idx);  // [RL22]
  assign tm.wdata = mem_wdata[8*(last - idx) +: 8];

  // Access sequencer
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      st          <= lbms_pkg::ST_IDLE;
      acc_ready   <= 1'b0;
      acc_err     <= 1'b0;
      acc_rdata   <= 32'h0000_0000;
      mem_addr    <= 32'h0000_0000;
      mem_we      <= 1'b0;
      mem_wdata   <= 32'h0000_0000;
      {flash_cs, rom_cs, sram_onb_cs, sram_mez_cs, dram_cs} <= 5'h00;
      rom_sock    <= 2'h0;
      dram_bank   <= 1'b0;
      par_irq     <= 1'b0;
      wcnt        <= 4'h0;
      idx         <= 2'h0;
      last        <= 2'h0;
    end
    else if (ce)
    begin
      acc_ready <= 1'b0;
      acc_err   <= 1'b0;
      par_irq   <= 1'b0;
      case (st)
        lbms_pkg::ST_IDLE:
          if (acc_valid && !acc_ready)
          begin
            mem_addr  <= acc_addr;
            mem_we    <= acc_we;
            mem_wdata <= acc_wdata;
            case (region(acc_addr, sram_mezz_present))
              lbms_pkg::R_TOD:
              begin
                idx       <= 2'h0;
                last      <= (acc_size == 2'h0) ? 2'h0 :
                             (acc_size == 2'h1) ? 2'h1 : 2'h3;  // [RL20]
                acc_rdata <= 32'h0000_0000;
                st        <= lbms_pkg::ST_TREQ;
              end
              lbms_pkg::R_SRAM:
              begin
                wcnt        <= swait_reg;  // [RL11]
                sram_onb_cs <= !blk && !sram_mezz_present;  // [RL7] [RL9]
                sram_mez_cs <= !blk && sram_mezz_present;
                st          <= lbms_pkg::ST_SRAM;
              end
              lbms_pkg::R_BOOT:
              begin
                flash_cs <= boot_flash_sel;  // [RL3] [RL5]
                rom_cs   <= !boot_flash_sel;
                rom_sock <= acc_addr[ROM_SHIFT(rom_density_strap) +: 2];
                st       <= lbms_pkg::ST_EXT;
              end
              lbms_pkg::R_DRAM:
              begin
                dram_cs   <= 1'b1;
                dram_bank <= ctrl_reg[lbms_pkg::CTL_D4M] && acc_addr[2];
                st        <= lbms_pkg::ST_EXT;  // [RL12]
              end
              default:
              begin
                acc_ready <= 1'b1;
                acc_err   <= 1'b1;
              end
            endcase
          end
        lbms_pkg::ST_SRAM:
          if (wcnt == 4'h0)
          begin
            {sram_onb_cs, sram_mez_cs} <= 2'h0;
            acc_rdata <= ext_rdata;  // [RL8]
            acc_ready <= 1'b1;
            st        <= lbms_pkg::ST_IDLE;
          end
          else
            wcnt <= wcnt - 4'h1;
        lbms_pkg::ST_EXT:
          if (ext_ack)
          begin
            {flash_cs, rom_cs, dram_cs} <= 3'h0;
            acc_rdata <= ext_rdata;
            acc_ready <= 1'b1;
            if (dram_cs && !mem_we && ctrl_reg[lbms_pkg::CTL_PEN] &&
                par_bad)
            begin
              acc_err <= ctrl_reg[lbms_pkg::CTL_PEXC];  // [RL13]
              par_irq <= !ctrl_reg[lbms_pkg::CTL_PEXC];
            end
            st <= lbms_pkg::ST_IDLE;
          end
        lbms_pkg::ST_TREQ:
          st <= lbms_pkg::ST_TCAP;
        lbms_pkg::ST_TCAP:
        begin
          acc_rdata <= {acc_rdata[23:0], tm.rdata};  // [RL1] [RL22]
          if (idx == last)
          begin
            acc_ready <= 1'b1;
            st        <= lbms_pkg::ST_IDLE;
          end
          else
          begin
            idx <= idx + 2'h1;
            st  <= lbms_pkg::ST_TREQ;
          end
        end
        default:
          st <= lbms_pkg::ST_IDLE;
      endcase
    end
  end

  function automatic int ROM_SHIFT(input logic [1:0] d);
    return lbms_pkg::ROM_AW0 + int'(d);  // [RL4]
  endfunction

  sequence tod_word_start;
    ce && st == lbms_pkg::ST_IDLE && acc_valid && !acc_ready &&
    acc_addr[31:13] == lbms_pkg::TOD_TAG && acc_size == 2'h2;
  endsequence

  a_grant_onehot: assert property (@(posedge clk_sys) disable iff (rst)
    $onehot0(lb_gnt)) else $error("two grants");  // [RL23]
  a_grant_hold: assert property (@(posedge clk_sys) disable iff (rst)
    lb_busy |=> $stable(lb_gnt)) else $error("grant moved");  // [RL23]
  a_grant_prio: assert property (@(posedge clk_sys) disable iff (rst)
    ce && !lb_busy && (lb_gnt & lb_req) == '0 && lb_req[0]
    |=> lb_gnt[0]) else $error("priority lost");  // [RL2]
  a_boot_select: assert property (@(posedge clk_sys) disable iff (rst)
    flash_cs |-> boot_flash_sel && !rom_cs)
    else $error("wrong boot device");  // [RL3]
  a_sram_mezz: assert property (@(posedge clk_sys) disable iff (rst)
    sram_onb_cs |-> !sram_mezz_present)
    else $error("onboard sram with mezzanine");  // [RL7]
  a_sram_block: assert property (@(posedge clk_sys) disable iff (rst)
    sram_start && blk |=> !sram_onb_cs && !sram_mez_cs)
    else $error("second cycle not blocked");  // [RL9]
  a_sram_wait: assert property (@(posedge clk_sys) disable iff (rst)
    ce && st == lbms_pkg::ST_SRAM && wcnt != 4'h0 |=> !acc_ready)
    else $error("sram acked early");  // [RL11]
  a_dram_off: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(dram_cs) |-> $past(ctrl_reg[lbms_pkg::CTL_DEN]))
    else $error("dram while disabled");  // [RL15]
  a_par_exc: assert property (@(posedge clk_sys) disable iff (rst)
    ce && st == lbms_pkg::ST_EXT && ext_ack && dram_cs && !mem_we &&
    ctrl_reg[lbms_pkg::CTL_PEN] && par_bad
    |=> acc_err == ctrl_reg[lbms_pkg::CTL_PEXC] && par_irq != acc_err)
    else $error("parity report wrong");  // [RL13]
  a_tod_word: assert property (@(posedge clk_sys) disable iff (rst)
    tod_word_start ##1 ce [*8] |=> acc_ready)
    else $error("clock word not four bytes");  // [RL22]
endmodule

// ==== sim/lbms_mem_model.sv ====
// Flash, ROM and DRAM devices answering the external cycles
module lbms_mem_model (
  // Clock
  input  wire logic        clk_sys,
  // Request from the subsystem
  input  wire logic [31:0] mem_addr,
  input  wire logic        flash_cs,
  input  wire logic        rom_cs,
  input  wire logic        dram_cs,
  // Behaviour set by the bench
  input  wire logic [3:0]  dly,
  input  wire logic        bad_par,
  // Answer
  output logic             ext_ack,
  output logic [31:0]      ext_rdata,
  output logic [3:0]       ext_rpar
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0]  cnt;
  logic        done;
  logic        sel;
  logic [31:0] d;
  assign sel = flash_cs | rom_cs | dram_cs;
  assign d   = mem_addr ^ 32'h5a5aa5a5;
  initial
  begin
    {ext_ack, ext_rdata, ext_rpar, cnt, done} = '0;
  end
  always @(posedge clk_sys)
  begin
    ext_ack <= 1'b0;
    if (sel && !done && cnt == dly)
    begin
      ext_ack   <= 1'b1;
      done      <= 1'b1;
      ext_rdata <= d;
      // Bad lane only when the bench asks for it
      ext_rpar  <= {~^d[31:24], ~^d[23:16], ~^d[15:8], ~^d[7:0] ^ bad_par};
    end
    else
      ext_rdata <= ~ext_rdata; // Bus inverts its data on every cycle without ack, so stale data returns every other cycle
    cnt <= (sel && !done) ? cnt + 4'h1 : 4'h0;
    if (!sel)
      done <= 1'b0;
  end
endmodule

// ==== sim/lbms_top_tb.sv ====
// Self-checking bench of the local bus memory subsystem
module lbms_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [31:0] m; logic e; logic [31:0] d;} lbms_exp_t;
  logic clk_sys, rst, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
    s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
    s_axi_rvalid, s_axi_rready, lb_busy, boot_source_strap, sram_mezz_present,
    backup_low, power_fail, tod_tick, acc_valid, acc_we, acc_ready, acc_err,
    mem_we, flash_cs, rom_cs, sram_onb_cs, sram_mez_cs, dram_cs, dram_bank,
    ext_ack, boot_flash_sel, par_irq, bad_par, fl_seen, irq_seen;
  logic [1:0] s_axi_bresp, s_axi_rresp, rom_density_strap, acc_size, rom_sock;
  logic [3:0] s_axi_wstrb, ext_rpar, dly;
  logic [4:0] lb_req, lb_gnt, eg;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, acc_addr, acc_wdata, acc_rdata,
    mem_addr, mem_wdata, ext_rdata;
  int err_count, num_checks, i;
  lbms_exp_t lq[$], aq[$];
  lbms_top i_dut (.*);
  lbms_mem_model i_mem (.*);
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task tmo(input int k, input int lim);
    if (k >= lim)
    begin
      chk("wait", 0, 1);
      tally_and_finish();
    end
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    int k;
    @(posedge clk_sys);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    k = 0;
    tb = 0;
    while (!tb && k < 50)
    begin
      @(negedge clk_sys);
      ta = s_axi_awready & s_axi_awvalid;
      tw = s_axi_wready & s_axi_wvalid;
      tb = s_axi_bvalid;
      if (tb) chk("bresp", er, s_axi_bresp);
      @(posedge clk_sys);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      k++;
    end
    s_axi_bready <= 1'b0;
    tmo(k, 50);
  endtask
  task axr(input logic [7:0] a, input logic [31:0] m, input logic e,
           input logic [31:0] d);
    logic ta, tr;
    int k;
    aq.push_back({m, e, d & m});
    @(posedge clk_sys);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    k = 0;
    tr = 0;
    while (!tr && k < 50)
    begin
      @(negedge clk_sys);
      ta = s_axi_arready & s_axi_arvalid;
      tr = s_axi_rvalid;
      @(posedge clk_sys);
      if (ta) s_axi_arvalid <= 1'b0;
      k++;
    end
    s_axi_rready <= 1'b0;
    tmo(k, 50);
  endtask
  task acc(input logic [31:0] a, input logic [1:0] sz, input logic we,
           input logic [31:0] wd, input logic [31:0] m, input logic e,
           input logic [31:0] d, input int cyc);
    logic r;
    int k;
    lq.push_back({m, e, d & m});
    @(posedge clk_sys);
    {acc_addr, acc_size, acc_we, acc_wdata, acc_valid} <= {a, sz, we, wd, 1'b1};
    k = 0;
    r = 0;
    fl_seen = 0;
    while (!r && k < 200)
    begin
      @(negedge clk_sys);
      r = acc_ready;
      fl_seen |= flash_cs;
      irq_seen |= par_irq;
      @(posedge clk_sys);
      k++;
    end
    acc_valid <= 1'b0;
    tmo(k, 200);
    if (cyc > 0) chk("cycles", cyc, k);
  endtask
  // Oldest note against each completed result
  always @(negedge clk_sys)
  begin
    lbms_exp_t x;
    if (acc_ready)
    begin
      x = lq.pop_front();
      chk("acc_err", x.e, acc_err);
      chk("acc_rdata", x.d, acc_rdata & x.m);
    end
    if (s_axi_rvalid && s_axi_rready)
    begin
      x = aq.pop_front();
      chk("rresp", x.e, s_axi_rresp[1]);
      chk("rdata", x.d, s_axi_rdata & x.m);
    end
  end
  initial
  begin
    {rst, ce, boot_source_strap, s_axi_wstrb} = 7'h7f;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {lb_busy, backup_low, power_fail, tod_tick, bad_par, dly, lb_req} = '0;
    {acc_valid, acc_we, acc_addr, acc_size, acc_wdata, eg} = '0;
    {err_count, num_checks, irq_seen} = '0;
    void'($urandom(85337));
    rom_density_strap = 2'($urandom);
    sram_mezz_present = 1'($urandom);
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    chk("boot_flash_sel", 1, boot_flash_sel);
    axr(lbms_pkg::REG_CTRL, 32'hf, 0, 0);
    axr(lbms_pkg::REG_SWAIT, 32'hf, 0, 3);
    axr(lbms_pkg::REG_DMASK, 32'hfff, 0, 32'hfff);
    axr(lbms_pkg::REG_DATE, '1, 0, 32'h00010101);
    axr(8'h40, 0, 1, 0);
    axw(8'h40, 0, lbms_pkg::RESP_ERR);
    axr(lbms_pkg::REG_STAT, 32'h3f, 0,
        {sram_mezz_present, rom_density_strap, 1'b1});
    $display("test registers done");
    for (i = 0; i < 8; i++)
    begin
      @(posedge clk_sys);
      lb_req <= 5'($urandom);
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      if ((lb_req & eg) == 0) eg = lb_req & (~lb_req + 5'h1);
      chk("lb_gnt", eg, lb_gnt);
    end
    @(posedge clk_sys);
    tod_tick <= 1'b1;
    @(posedge clk_sys);
    tod_tick <= 1'b0;
    axr(lbms_pkg::REG_TIME, '1, 0, 1);
    $display("test arbiter and clock done");
    for (i = 0; i < 2; i++)
    begin
      backup_low <= i[0];
      axw(lbms_pkg::REG_SWAIT, i * 5, 0);
      acc(32'hffe00000, 2, 1, 32'h1234, 0, 0, 0, i * 5 + 3);
      acc(32'hffe00004, 2, 0, 0, 0, 0, 0, i * 5 + 3);
    end
    acc(32'hff800000, 2, 0, 0, 0, 0, 0, 0);
    chk("flash_cs", 1, fl_seen);
    acc(32'hfffc0010, 2, 1, 32'h11223344, 0, 0, 0, 10);
    acc(32'hfffc0010, 0, 0, 0, 32'hff, 0, 32'h11, 4);
    acc(32'hfffc0012, 1, 0, 0, 32'hffff, 0, 32'h3344, 6);
    acc(32'hfffc0010, 2, 0, 0, '1, 0, 32'h11223344, 10);
    $display("test sram boot clock done");
    acc(32'h00100000, 2, 0, 0, 0, 1, 0, 0);
    axw(lbms_pkg::REG_DBASE, 1, 0);
    axw(lbms_pkg::REG_CTRL, 7, 0);
    for (i = 0; i < 10; i++)
    begin
      dly <= 4'(i);
      acc(32'h00100000 + i * 4, 2, 0, 0, '1, 0,
          (32'h00100000 + i * 4) ^ 32'h5a5aa5a5, 0);
    end
    bad_par <= 1'b1;
    acc(32'h00100000, 2, 0, 0, 0, 1, 0, 0);
    axw(lbms_pkg::REG_CTRL, 3, 0);
    irq_seen = 0;
    acc(32'h00100000, 2, 0, 0, 0, 0, 0, 0);
    chk("par_irq", 1, irq_seen);
    bad_par <= 1'b0;
    acc(32'h80000000, 2, 0, 0, 0, 1, 0, 0);
    $display("test dram done");
    tally_and_finish();
  end
endmodule
